// file: rtl/rcs_top.sv
`timescale 1ns/1ps
// Summary of operation
// (RL1) The reset cause register has four implemented bits, the rest read 0.
// (RL2) Bit 0 is the brown-out flag, software may write it at any time.
// (RL3) Software sets the brown-out flag and a brown-out reset clears it.
// (RL4) With brown-out detection off, brown-out events are ignored.
// (RL5) Bit 1 is cleared by power-on and kept through all other resets.
// (RL6) Software sets the power-on flag after each power-on reset.
// (RL7) Bit 2 is cleared by a parity error reset and set again by software.
// (RL8) A power-on reset forces the parity error flag to one.
// (RL9) Bit 7 reads back the parity check enable of the configuration word.
// (RL10) That mirror bit is untouched by any reset or interrupt.
// (RL11) Start-up delay follows oscillator mode, timer enable and source.
// (RL12) A parity failure resets and marks the parity error flag.
// (RL13) The power-up timer disable bit, when set, skips the 72 ms delay after power-on only.
module rcs_top #(
  parameter int unsigned PWRT_CYCLES = rcs_pkg::PWRT_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [rcs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data
  input wire logic [rcs_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [rcs_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address
  input wire logic [rcs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data
  output logic [rcs_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // reset source indications, asynchronous levels
  input wire logic por_req_async,
  input wire logic bor_req_async,
  input wire logic parity_err_async,
  input wire logic wake_async,
  // configuration word
  input wire logic parity_check_enable,
  input wire logic brownout_detect_enable,
  input wire logic powerup_timer_disable,
  input wire rcs_pkg::rcs_osc_mode_t osc_mode,
  // outputs
  output logic startup_hold,
  output logic irq
);

  // ----------------------------------------
  // source synchronisation
  // ----------------------------------------
  logic [rcs_pkg::EVT_W-1:0] evt_raw;
  logic [rcs_pkg::EVT_W-1:0] evt_rise_raw;
  rcs_pkg::rcs_evt_t evt_rise;

  assign evt_raw = {por_req_async, bor_req_async, parity_err_async,
                    wake_async};

  rcs_sync #(
    .W(rcs_pkg::EVT_W)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(evt_raw),
    .level(),
    .rise(evt_rise_raw)
  );

  assign evt_rise = rcs_pkg::rcs_evt_t'(evt_rise_raw);

  logic por_ev;
  logic bor_ev;
  logic par_ev;
  logic wake_ev;

  assign por_ev = evt_rise.por;
  assign bor_ev = evt_rise.bor & brownout_detect_enable; // [RL4]
  assign par_ev = evt_rise.parity & parity_check_enable; // [RL12]
  assign wake_ev = evt_rise.wake;

  // ----------------------------------------
  // start-up delay sequencer
  // ----------------------------------------
  localparam logic [rcs_pkg::CNT_W-1:0] PWRT_LOAD =
    rcs_pkg::CNT_W'(PWRT_CYCLES);
  localparam logic [rcs_pkg::CNT_W-1:0] OST_LOAD =
    rcs_pkg::CNT_W'(rcs_pkg::OST_CYC);

  rcs_pkg::rcs_seq_state_t seq_r;
  rcs_pkg::rcs_seq_state_t seq_nxt;
  logic is_rc;
  logic seq_idle;
  logic start_pwrt;
  logic start_ost;
  logic ost_after_pwrt;
  logic cnt_load;
  logic [rcs_pkg::CNT_W-1:0] cnt_val;
  logic cnt_done;
  logic seq_done_ev;

  assign is_rc = osc_mode == rcs_pkg::RESISTOR_CAP_OSC_MODE;
  assign seq_idle = seq_r == rcs_pkg::SEQ_IDLE;

  // brown-out always gets the timer; a new one restarts it
  assign start_pwrt = (por_ev & ~powerup_timer_disable) | bor_ev; // [RL13]
  // rc mode has no oscillator settle time at all
  assign start_ost = ~is_rc & ~start_pwrt &
                     ((por_ev & powerup_timer_disable) |
                      (wake_ev & seq_idle)); // [RL11]
  assign ost_after_pwrt = (seq_r == rcs_pkg::SEQ_PWRT) & cnt_done &
                          ~is_rc & ~start_pwrt & ~start_ost; // [RL11]

  always_comb begin
    seq_nxt = seq_r;
    if (start_pwrt) begin
      seq_nxt = rcs_pkg::SEQ_PWRT;
    end else if (start_ost) begin
      seq_nxt = rcs_pkg::SEQ_OST;
    end else begin
      case (seq_r)
        rcs_pkg::SEQ_PWRT: begin
          if (cnt_done) begin
            seq_nxt = is_rc ? rcs_pkg::SEQ_IDLE : rcs_pkg::SEQ_OST;
          end
        end
        rcs_pkg::SEQ_OST: begin
          if (cnt_done) begin
            seq_nxt = rcs_pkg::SEQ_IDLE;
          end
        end
        default: begin
          seq_nxt = rcs_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  assign cnt_load = start_pwrt | start_ost | ost_after_pwrt;
  assign cnt_val = start_pwrt ? PWRT_LOAD : OST_LOAD; // [RL11]
  assign seq_done_ev = ~seq_idle & (seq_nxt == rcs_pkg::SEQ_IDLE);

  rcs_delay_cnt u_delay (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(cnt_load),
    .load_val(cnt_val),
    .done(cnt_done)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_r <= rcs_pkg::SEQ_IDLE;
    end else begin
      seq_r <= seq_nxt;
    end
  end

  assign startup_hold = ~seq_idle;

  // ----------------------------------------
  // axi4-lite write path
  // ----------------------------------------
  logic aw_full_r;
  logic w_full_r;
  logic [rcs_pkg::ADDR_W-1:0] awaddr_r;
  logic [rcs_pkg::DATA_W-1:0] wdata_r;
  logic [rcs_pkg::STRB_W-1:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic wr_fire;
  logic wsel_cause;
  logic wsel_istat;
  logic wsel_imask;
  logic wsel_hit;
  logic wr_cause;
  logic wr_istat;
  logic wr_imask;

  assign s_axi_awready = ~aw_full_r;
  assign s_axi_wready = ~w_full_r;
  assign wr_fire = aw_full_r & w_full_r & ~bvalid_r;

  assign wsel_cause = awaddr_r == rcs_pkg::CAUSE_ADDR;
  assign wsel_istat = awaddr_r == rcs_pkg::ISTAT_ADDR;
  assign wsel_imask = awaddr_r == rcs_pkg::IMASK_ADDR;
  // sequencer status is read only but answers okay
  assign wsel_hit = wsel_cause | wsel_istat | wsel_imask |
                    (awaddr_r == rcs_pkg::SEQ_ADDR);
  // all fields sit in byte lane 0
  assign wr_cause = wr_fire & wsel_cause & wstrb_r[0];
  assign wr_istat = wr_fire & wsel_istat & wstrb_r[0];
  assign wr_imask = wr_fire & wsel_imask & wstrb_r[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'h0;
      awaddr_r <= '0;
    end else if (s_axi_awvalid & ~aw_full_r) begin
      aw_full_r <= 1'h1;
      awaddr_r <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_full_r <= 1'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_r <= 1'h0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (s_axi_wvalid & ~w_full_r) begin
      w_full_r <= 1'h1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_full_r <= 1'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'h0;
      bresp_r <= rcs_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'h1;
      bresp_r <= wsel_hit ? rcs_pkg::RESP_OKAY : rcs_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'h0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // ----------------------------------------
  // reset cause flags
  // ----------------------------------------
  // hardware events beat a software write in the same cycle
  rcs_pkg::rcs_cause_t cause_r;
  rcs_pkg::rcs_cause_t cause_nxt;
  logic w_bor;
  logic w_por;
  logic w_per;

  assign w_bor = wdata_r[rcs_pkg::BOR_BIT];
  assign w_por = wdata_r[rcs_pkg::POR_BIT];
  assign w_per = wdata_r[rcs_pkg::PER_BIT];

  assign cause_nxt.brownout_flag =
    bor_ev ? 1'h0 : // [RL3]
    wr_cause ? w_bor : cause_r.brownout_flag; // [RL2]
  assign cause_nxt.por_flag =
    por_ev ? 1'h0 : // [RL5]
    wr_cause ? w_por : cause_r.por_flag; // [RL6]
  assign cause_nxt.parity_error_flag =
    por_ev ? 1'h1 : // [RL8]
    par_ev ? 1'h0 : // [RL7]
    wr_cause ? w_per : cause_r.parity_error_flag;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_r <= rcs_pkg::CAUSE_RST;
    end else begin
      cause_r <= cause_nxt;
    end
  end

  // ----------------------------------------
  // interrupt status and mask
  // ----------------------------------------
  logic [rcs_pkg::INT_W-1:0] istat_r;
  logic [rcs_pkg::INT_W-1:0] imask_r;
  logic [rcs_pkg::INT_W-1:0] int_set;
  logic [rcs_pkg::INT_W-1:0] int_clr;

  always_comb begin
    int_set = '0;
    int_set[rcs_pkg::IRQ_BOR] = bor_ev;
    int_set[rcs_pkg::IRQ_POR] = por_ev;
    int_set[rcs_pkg::IRQ_PER] = par_ev;
    int_set[rcs_pkg::IRQ_DONE] = seq_done_ev;
  end

  assign int_clr = wr_istat ? wdata_r[rcs_pkg::INT_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      istat_r <= rcs_pkg::ISTAT_RST;
      imask_r <= rcs_pkg::IMASK_RST;
    end else begin
      istat_r <= (istat_r & ~int_clr) | int_set;
      if (wr_imask) begin
        imask_r <= wdata_r[rcs_pkg::INT_W-1:0];
      end
    end
  end

  assign irq = |(istat_r & imask_r);

  // ----------------------------------------
  // axi4-lite read path
  // ----------------------------------------
  logic [rcs_pkg::DATA_W-1:0] cause_word;
  logic [rcs_pkg::DATA_W-1:0] seq_word;
  logic [rcs_pkg::DATA_W-1:0] rd_mux;
  logic rsel_cause;
  logic rsel_istat;
  logic rsel_imask;
  logic rsel_seq;
  logic rsel_hit;
  logic rvalid_r;
  logic [rcs_pkg::DATA_W-1:0] rdata_r;
  logic [1:0] rresp_r;

  always_comb begin
    cause_word = '0; // [RL1]
    cause_word[rcs_pkg::BOR_BIT] = cause_r.brownout_flag;
    cause_word[rcs_pkg::POR_BIT] = cause_r.por_flag;
    cause_word[rcs_pkg::PER_BIT] = cause_r.parity_error_flag;
    // live mirror, no flop to reset [RL10]
    cause_word[rcs_pkg::MIRROR_BIT] = parity_check_enable; // [RL9]
  end

  always_comb begin
    seq_word = '0;
    seq_word[rcs_pkg::SEQ_HOLD_BIT] = startup_hold;
    seq_word[rcs_pkg::SEQ_ST_LSB +: 2] = seq_r;
    seq_word[rcs_pkg::SEQ_PTD_BIT] = powerup_timer_disable;
    seq_word[rcs_pkg::SEQ_BDE_BIT] = brownout_detect_enable;
    seq_word[rcs_pkg::SEQ_OSC_LSB +: 2] = osc_mode;
  end

  assign rsel_cause = s_axi_araddr == rcs_pkg::CAUSE_ADDR;
  assign rsel_istat = s_axi_araddr == rcs_pkg::ISTAT_ADDR;
  assign rsel_imask = s_axi_araddr == rcs_pkg::IMASK_ADDR;
  assign rsel_seq = s_axi_araddr == rcs_pkg::SEQ_ADDR;
  assign rsel_hit = rsel_cause | rsel_istat | rsel_imask | rsel_seq;

  assign rd_mux =
    rsel_cause ? cause_word :
    rsel_istat ? {{(rcs_pkg::DATA_W - rcs_pkg::INT_W){1'h0}}, istat_r} :
    rsel_imask ? {{(rcs_pkg::DATA_W - rcs_pkg::INT_W){1'h0}}, imask_r} :
    rsel_seq ? seq_word : '0;

  assign s_axi_arready = ~rvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'h0;
      rdata_r <= '0;
      rresp_r <= rcs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid & ~rvalid_r) begin
      rvalid_r <= 1'h1;
      rdata_r <= rd_mux;
      rresp_r <= rsel_hit ? rcs_pkg::RESP_OKAY : rcs_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'h0;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

endmodule

// file: rtl/rcs_pkg.sv
package rcs_pkg;

  // ----------------------------------------
  // bus geometry and register map
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;

  // register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] CAUSE_IDX = 12'h08e;
  localparam logic [ADDR_W-1:0] ISTAT_IDX = 12'h090;
  localparam logic [ADDR_W-1:0] IMASK_IDX = 12'h091;
  localparam logic [ADDR_W-1:0] SEQ_IDX = 12'h092;
  localparam logic [ADDR_W-1:0] CAUSE_ADDR = {CAUSE_IDX[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] ISTAT_ADDR = {ISTAT_IDX[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] IMASK_ADDR = {IMASK_IDX[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] SEQ_ADDR = {SEQ_IDX[ADDR_W-3:0], 2'h0};

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BOR_BIT = 0;
  localparam int POR_BIT = 1;
  localparam int PER_BIT = 2;
  localparam int MIRROR_BIT = 7;

  localparam int SEQ_HOLD_BIT = 0;
  localparam int SEQ_ST_LSB = 1;
  localparam int SEQ_PTD_BIT = 4;
  localparam int SEQ_BDE_BIT = 5;
  localparam int SEQ_OSC_LSB = 6;

  localparam int INT_W = 4;
  localparam int IRQ_BOR = 0;
  localparam int IRQ_POR = 1;
  localparam int IRQ_PER = 2;
  localparam int IRQ_DONE = 3;
  localparam logic [INT_W-1:0] ISTAT_RST = 4'h0;
  localparam logic [INT_W-1:0] IMASK_RST = 4'h0;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int PWRT_MS = 72;
  localparam int PWRT_CYC = PWRT_MS * (CLK_HZ / 1000);
  // one oscillator period taken as one core clock
  localparam int OST_TOSC = 1024;
  localparam int OST_CYC = OST_TOSC;
  localparam int CNT_W = 22;
  localparam logic [CNT_W-1:0] CNT_ONE = 22'h00_0001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 22'h00_0000;

  // ----------------------------------------
  // types
  // ----------------------------------------
  localparam int EVT_W = 4;

  typedef enum logic [1:0] {
    LOW_POWER_OSC_MODE = 2'h0,
    CRYSTAL_OSC_MODE = 2'h1,
    HIGH_SPEED_OSC_MODE = 2'h2,
    RESISTOR_CAP_OSC_MODE = 2'h3
  } rcs_osc_mode_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_PWRT = 2'h1,
    SEQ_OST = 2'h2
  } rcs_seq_state_t;

  typedef struct packed {
    logic por;
    logic bor;
    logic parity;
    logic wake;
  } rcs_evt_t;

  typedef struct packed {
    logic parity_error_flag;
    logic por_flag;
    logic brownout_flag;
  } rcs_cause_t;

  localparam rcs_cause_t CAUSE_RST = '{
    parity_error_flag: 1'h1, por_flag: 1'h0, brownout_flag: 1'h0};

endpackage

// file: rtl/rcs_sync.sv
`timescale 1ns/1ps
module rcs_sync #(
  parameter int W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] level,
  output logic [W-1:0] rise
);

  // ----------------------------------------
  // three stages, accept when last two agree
  // ----------------------------------------
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] lvl_r;
  logic [W-1:0] lvl_nxt;
  logic [W-1:0] rise_r;

  // stage one feeds stage two only
  assign lvl_nxt = (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      lvl_r <= '0;
      rise_r <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
      rise_r <= lvl_nxt & ~lvl_r;
    end
  end

  assign level = lvl_r;
  assign rise = rise_r;

endmodule

// file: rtl/rcs_delay_cnt.sv
`timescale 1ns/1ps
module rcs_delay_cnt (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load,
  input wire logic [rcs_pkg::CNT_W-1:0] load_val,
  output logic done
);

  // ----------------------------------------
  // down counter, reload restarts the delay
  // ----------------------------------------
  logic [rcs_pkg::CNT_W-1:0] cnt_r;
  logic [rcs_pkg::CNT_W-1:0] cnt_nxt;
  logic running;

  assign running = cnt_r != rcs_pkg::CNT_ZERO;
  assign cnt_nxt = load ? load_val :
                   running ? cnt_r - rcs_pkg::CNT_ONE : cnt_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= rcs_pkg::CNT_ZERO;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // last cycle of the delay
  assign done = cnt_r == rcs_pkg::CNT_ONE;

endmodule

// file: tb/rcs_monitor.sv
`timescale 1ns/1ps
module rcs_monitor #(
  parameter int unsigned PWRT_CYCLES = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [rcs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [rcs_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic por_req_async,
  input wire logic bor_req_async,
  input wire logic parity_check_enable,
  input wire logic brownout_detect_enable,
  input wire logic powerup_timer_disable,
  input wire rcs_pkg::rcs_osc_mode_t osc_mode,
  input wire logic startup_hold
);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  logic [rcs_pkg::ADDR_W-1:0] ar_addr_r;
  logic ar_pce_r;
  logic [23:0] hold_cnt_r;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire cause_rd = s_axi_rvalid && (ar_addr_r == rcs_pkg::CAUSE_ADDR);
  wire rc_mode = osc_mode == rcs_pkg::RESISTOR_CAP_OSC_MODE;
  wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
                 s_axi_wready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_addr_r <= 12'h000;
      ar_pce_r <= 1'b0;
    end else if (ar_take) begin
      ar_addr_r <= s_axi_araddr;
      ar_pce_r <= parity_check_enable;
    end
  end
  // counter, a repetition this long would not unroll
  always_ff @(posedge aclk) begin
    if (!aresetn || !startup_hold) begin
      hold_cnt_r <= 24'h00_0000;
    end else begin
      hold_cnt_r <= hold_cnt_r + 24'h00_0001;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_hold_soon;
    ##[2:8] startup_hold;
  endsequence
  sequence s_quiet;
    !startup_hold [*8];
  endsequence
  property p_rd_lat;
    ar_take |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rd_once;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rd_once: assert property (p_rd_once) else $error("read answer kept");
  property p_wr_lat;
    wr_take |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_cause_bits;
    cause_rd |-> s_axi_rdata[31:8] == 24'h00_0000 && s_axi_rdata[6:3] == 4'h0;
  endproperty
  a_cause_bits: assert property (p_cause_bits)
    else $error("unused cause bits set");
  property p_mirror;
    cause_rd |-> s_axi_rdata[7] == ar_pce_r;
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("mirror bit wrong");
  property p_por_hold;
    $rose(por_req_async) && !(powerup_timer_disable && rc_mode) |-> s_hold_soon;
  endproperty
  a_por_hold: assert property (p_por_hold)
    else $error("no delay after power-on");
  property p_por_quiet;
    $rose(por_req_async) && powerup_timer_disable && rc_mode |-> s_quiet;
  endproperty
  a_por_quiet: assert property (p_por_quiet)
    else $error("delay without cause");
  property p_bor_hold;
    $rose(bor_req_async) && brownout_detect_enable |-> s_hold_soon;
  endproperty
  a_bor_hold: assert property (p_bor_hold)
    else $error("no delay after brown-out");
  property p_hold_len;
    hold_cnt_r <= PWRT_CYCLES + rcs_pkg::OST_CYC + 2;
  endproperty
  a_hold_len: assert property (p_hold_len)
    else $error("delay too long");
endmodule

bind rcs_top rcs_monitor #(.PWRT_CYCLES(PWRT_CYCLES)) rcs_monitor_inst (.*);

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int P = 20;
  localparam int OST = rcs_pkg::OST_CYC;
  localparam logic [11:0] CA = rcs_pkg::CAUSE_ADDR;
  localparam logic [11:0] IS = rcs_pkg::ISTAT_ADDR;
  localparam logic [11:0] IM = rcs_pkg::IMASK_ADDR;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, startup_hold, irq;
  logic parity_check_enable, brownout_detect_enable, powerup_timer_disable;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, ev;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  rcs_pkg::rcs_osc_mode_t osc_mode;
  wire por_req_async = ev[0];
  wire bor_req_async = ev[1];
  wire parity_err_async = ev[2];
  wire wake_async = ev[3];
  int err_total, checks_done, seed;
  // source: 0 power-on, 1 brown-out, 2 parity, 3 wake
  int src_t[11] = '{0, 0, 0, 0, 1, 1, 1, 3, 3, 2, 2};
  int osc_t[11] = '{1, 2, 3, 3, 0, 3, 1, 2, 3, 1, 0};
  bit ptd_t[11] = '{0, 1, 0, 1, 0, 0, 0, 1, 0, 0, 0};
  bit bde_t[11] = '{1, 1, 0, 1, 1, 1, 0, 1, 1, 1, 1};
  bit pce_t[11] = '{1, 0, 1, 1, 0, 1, 1, 1, 1, 1, 0};

  rcs_top #(.PWRT_CYCLES(P)) rcs_top_inst (.*);

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    bit aw_ok = 0;
    bit w_ok = 0;
    int n;
    r = 2'h3;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (aw_ok && w_ok && s_axi_bvalid === 1'b1) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    if (n == 40) begin
      err_total++;
      give_verdict();
    end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e,
                      input logic [1:0] er);
    bit ar_ok = 0;
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (ar_ok && s_axi_rvalid === 1'b1) begin
        chk(s_axi_rdata, e);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        s_axi_rready <= 1'b0;
        break;
      end
      if (!ar_ok && s_axi_arready === 1'b1) begin
        ar_ok = 1;
        s_axi_arvalid <= 1'b0;
      end
    end
    if (n == 40) begin
      err_total++;
      give_verdict();
    end
  endtask
  // pulse one source and count the cycles that the delay holds
  task automatic evt(input int s, input int e, output int c);
    c = 0;
    @(posedge aclk);
    ev[s] <= 1'b1;
    for (int i = 0; i < e + 60; i++) begin
      @(posedge aclk);
      if (i == 4) ev[s] <= 1'b0;
      if (startup_hold === 1'b1) c++;
    end
  endtask
  // ----------------------------------------
  // expectations
  // ----------------------------------------
  function automatic int exp_dly(int s, int o, bit t, bit b);
    int ost;
    ost = (o == 3) ? 0 : OST;
    case (s)
      0: return t ? ost : P + ost;
      1: return b ? P + ost : 0;
      3: return ost;
      default: return 0;
    endcase
  endfunction
  function automatic logic [3:0] exp_ist(int s, bit b, bit pc, int d);
    logic [3:0] v;
    v = {d > 0, 3'b000};
    // source order differs from the status bit order
    if (s == 0) v[rcs_pkg::IRQ_POR] = 1'b1;
    if (s == 1 && b) v[rcs_pkg::IRQ_BOR] = 1'b1;
    if (s == 2 && pc) v[rcs_pkg::IRQ_PER] = 1'b1;
    return v;
  endfunction
  function automatic logic [2:0] exp_flg(int s, bit b, bit pc,
                                         logic [2:0] w);
    logic [2:0] v;
    v = w;
    if (s == 0) v[2:1] = 2'b10;
    if (s == 1 && b) v[0] = 1'b0;
    if (s == 2 && pc) v[2] = 1'b0;
    return v;
  endfunction
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int c, d;
    logic ok;
    logic [1:0] rsp;
    logic [3:0] m, ie;
    logic [31:0] w;
    seed = 92;
    err_total = 0;
    checks_done = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    ev = 4'h0;
    parity_check_enable = 1'b1;
    brownout_detect_enable = 1'b1;
    powerup_timer_disable = 1'b0;
    osc_mode = rcs_pkg::CRYSTAL_OSC_MODE;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(CA, 32'h0000_0084, rcs_pkg::RESP_OKAY);
    rchk(IS, 32'h0000_0000, rcs_pkg::RESP_OKAY);
    rchk(IM, 32'h0000_0000, rcs_pkg::RESP_OKAY);
    rchk(12'hffc, 32'h0000_0000, rcs_pkg::RESP_SLVERR);
    wr(12'hffc, 32'h0000_00ff, rsp);
    chk({30'h0, rsp}, {30'h0, rcs_pkg::RESP_SLVERR});
    $display("reset and map test done");
    for (int k = 0; k < 8; k++) begin
      w = (k == 0) ? 32'hffff_ffff : $random(seed);
      parity_check_enable <= w[31];
      wr(CA, w, rsp);
      chk({30'h0, rsp}, {30'h0, rcs_pkg::RESP_OKAY});
      rchk(CA, {24'h0, w[31], 4'h0, w[2:0]}, 2'h0);
    end
    $display("cause write test done");
    m = 4'($random(seed));
    m[3] = 1'b1;
    wr(IM, {28'h0, m}, rsp);
    rchk(IM, {28'h0, m}, 2'h0);
    for (int k = 0; k < 11; k++) begin
      w = $random(seed);
      // arm the flag that the event should clear, so a miss shows
      if (src_t[k] == 0) w[2:1] = 2'b01;
      if (src_t[k] == 1) w[0] = 1'b1;
      if (src_t[k] == 2) w[2] = 1'b1;
      osc_mode <= rcs_pkg::rcs_osc_mode_t'(osc_t[k]);
      powerup_timer_disable <= ptd_t[k];
      brownout_detect_enable <= bde_t[k];
      parity_check_enable <= pce_t[k];
      wr(CA, w, rsp);
      d = exp_dly(src_t[k], osc_t[k], ptd_t[k], bde_t[k]);
      evt(src_t[k], d, c);
      ok = (d == 0) ? (c == 0) : (c + 1 >= d && c <= d + 2);
      chk({31'h0, ok}, 32'h0000_0001);
      ie = exp_ist(src_t[k], bde_t[k], pce_t[k], d);
      rchk(CA, {24'h0, pce_t[k], 4'h0, exp_flg(src_t[k], bde_t[k],
           pce_t[k], w[2:0])}, 2'h0);
      rchk(IS, {28'h0, ie}, 2'h0);
      chk({31'h0, irq}, {31'h0, |(ie & m)});
      wr(IS, 32'h0000_000f, rsp);
      chk({31'h0, irq}, 32'h0000_0000);
    end
    $display("event and delay test done");
    parity_check_enable <= 1'b1;
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(CA, 32'h0000_0084, 2'h0);
    wr(rcs_pkg::SEQ_ADDR, 32'h0000_00ff, rsp);
    chk({30'h0, rsp}, {30'h0, rcs_pkg::RESP_OKAY});
    // idle, timer on, detector on, low-power oscillator
    rchk(rcs_pkg::SEQ_ADDR, 32'h0000_0020, 2'h0);
    $display("second reset test done");
    give_verdict();
  end
endmodule
